// ===== supervisor_pkg.sv
// Shared constants, register map and state codes for the supervisor block
package supervisor_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_MS = 1;
  localparam int RST_PULSE_SHORT_MS = 50;
  localparam int RST_PULSE_LONG_MS = 200;
  localparam int WD_SHORT_MS = 100;
  localparam int WD_LONG_MS = 1600;
  localparam int RST_PULSE_SHORT_TICKS = RST_PULSE_SHORT_MS / TICK_MS;
  localparam int RST_PULSE_LONG_TICKS = RST_PULSE_LONG_MS / TICK_MS;
  localparam int WD_SHORT_TICKS = WD_SHORT_MS / TICK_MS;
  localparam int WD_LONG_TICKS = WD_LONG_MS / TICK_MS;
  localparam int EXT_RST_TICKS = 64;
  localparam int EXT_WD_TICKS = 1024;
  localparam int CNT_W = 16;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam int CTRL_LONG_PULSE_BIT = 0;
  localparam int STAT_RESET_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_SUPPLY_LOW_BIT = 2;
  localparam int STAT_BACKUP_BIT = 3;
  localparam int STAT_LONG_TIMEOUT_BIT = 4;
  localparam int STAT_WD_ENABLED_BIT = 5;
  localparam int STAT_POWER_FAIL_BIT = 6;
  localparam int STAT_EXT_MODE_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Reset sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_SUPPLY_LOW = 3'b001,
    ST_STRETCH = 3'b010,
    ST_RUN = 3'b100
  } sup_state_e;

endpackage

// ===== input_sync.sv
// Two-stage synchroniser for asynchronous inputs
module input_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage1_d;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage2_d;

  always_comb begin
    stage1_d = async_i;
    stage2_d = stage1_q;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else if (clk_en_i) begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign sync_o = stage2_q;

endmodule

// ===== timebase_gen.sv
// Internal millisecond tick divider and external timebase edge ticks
module timebase_gen #(
  parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic ext_level_i,
  output logic int_tick_o,
  output logic ext_tick_o
);

  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic int_tick_q;
  logic int_tick_d;
  logic ext_prev_q;
  logic ext_prev_d;
  logic ext_tick_q;
  logic ext_tick_d;

  always_comb begin
    int_tick_d = (div_q == DIV_LAST);
    div_d = int_tick_d ? '0 : div_q + DIV_W'(1);
    ext_prev_d = ext_level_i;
    ext_tick_d = ext_level_i && !ext_prev_q;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= '0;
      int_tick_q <= 1'b0;
      ext_prev_q <= 1'b0;
      ext_tick_q <= 1'b0;
    end else if (clk_en_i) begin
      div_q <= div_d;
      int_tick_q <= int_tick_d;
      ext_prev_q <= ext_prev_d;
      ext_tick_q <= ext_tick_d;
    end
  end

  assign int_tick_o = int_tick_q;
  assign ext_tick_o = ext_tick_q;

endmodule

// ===== supervisor_reset_watchdog.sv
// Supervisor: reset stretcher, watchdog, supply flags and AXI4-Lite registers
// Overview of operation
// - Reset low while supply low, then stretched
// - Watchdog expiry gives one reset pulse
// - Kick input decoded high, low or floating
// - Any kick edge restarts the timeout
// - Floating kick disables the watchdog entirely
// - Power-fail flag low when sense below limit
// - Backup operation forces power-fail flag low
// - Chip-enable passes only while supply good
// - Backup indicator follows rail switch state
// - Supply-low flag follows threshold without delay
// - Active-high reset is inverse of reset
// - Select high picks internal timebase
// - External mode times reset pulse and short timeout from pin; long timeout stays internal
// - Internal mode: pin picks short/long timeout
// - Long timeout follows every reset
// - Fault output low on watchdog expiry
// - Next kick edge releases fault output
// - Fault held high while watchdog disabled
// - Fault forced high when supply low
// - Watchdog restarts at end of reset
// - First kick edge after release ends long timeout
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
module supervisor_reset_watchdog #(
  parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES,
  parameter int EXT_RST_TICKS = supervisor_pkg::EXT_RST_TICKS,
  parameter int EXT_WD_TICKS = supervisor_pkg::EXT_WD_TICKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic supply_ok_i,
  input wire logic on_backup_i,
  input wire logic power_fail_sense_i,
  input wire logic kick_high_i,
  input wire logic kick_low_i,
  input wire logic timebase_source_select_i,
  input wire logic external_timebase_in_i,
  input wire logic ce_in_n_i,
  output logic reset_n_o,
  output logic reset_o,
  output logic watchdog_fault_n_o,
  output logic supply_low_n_o,
  output logic power_fail_flag_n_o,
  output logic on_backup_supply_o,
  output logic ce_out_n_o,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i
);

  localparam int CW = supervisor_pkg::CNT_W;

  // ----------------------------------------
  // Input synchronisers and timebase
  // ----------------------------------------
  logic [7:0] raw_in;
  logic [7:0] sync_in;
  logic supply_ok_s;
  logic on_backup_s;
  logic pf_below_s;
  logic kick_high_s;
  logic kick_low_s;
  logic select_s;
  logic ext_level_s;
  logic ce_in_n_s;
  logic int_tick;
  logic ext_tick;

  assign raw_in = {ce_in_n_i, external_timebase_in_i, timebase_source_select_i, kick_low_i,
                   kick_high_i, power_fail_sense_i, on_backup_i, supply_ok_i};

  input_sync #(.WIDTH(8)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .async_i(raw_in),
    .sync_o(sync_in)
  );

  assign supply_ok_s = sync_in[0];
  assign on_backup_s = sync_in[1];
  assign pf_below_s = sync_in[2];
  assign kick_high_s = sync_in[3];
  assign kick_low_s = sync_in[4];
  assign select_s = sync_in[5];
  assign ext_level_s = sync_in[6];
  assign ce_in_n_s = sync_in[7];

  timebase_gen #(.TICK_CYCLES(TICK_CYCLES)) u_timebase (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .ext_level_i(ext_level_s),
    .int_tick_o(int_tick),
    .ext_tick_o(ext_tick)
  );

  // ----------------------------------------
  // Supervisor state
  // ----------------------------------------
  supervisor_pkg::sup_state_e state_q;
  supervisor_pkg::sup_state_e state_d;
  logic [CW-1:0] rst_cnt_q;
  logic [CW-1:0] rst_cnt_d;
  logic [CW-1:0] wd_cnt_q;
  logic [CW-1:0] wd_cnt_d;
  logic long_q;
  logic long_d;
  logic last_kick_q;
  logic last_kick_d;
  logic kick_seen_q;
  logic kick_seen_d;
  logic fault_n_q;
  logic fault_n_d;
  logic reset_n_q;
  logic reset_n_d;
  logic reset_q;
  logic supply_low_n_q;
  logic supply_low_n_d;
  logic pf_n_q;
  logic pf_n_d;
  logic backup_q;
  logic ce_out_n_q;
  logic ce_out_n_d;
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;

  logic ext_mode;
  logic kick_valid;
  logic kick_edge;
  logic rst_tick;
  logic wd_tick;
  logic [CW-1:0] pulse_last;
  logic [CW-1:0] wd_last;

  assign ext_mode = !select_s;
  assign kick_valid = kick_high_s ^ kick_low_s;
  assign kick_edge = kick_valid && kick_seen_q && (kick_high_s != last_kick_q);
  assign rst_tick = ext_mode ? ext_tick : int_tick;
  assign wd_tick = (long_q || !ext_mode) ? int_tick : ext_tick;

  always_comb begin
    if (ext_mode) begin
      pulse_last = CW'(EXT_RST_TICKS - 1);
    end else if (ctrl_q[supervisor_pkg::CTRL_LONG_PULSE_BIT]) begin
      pulse_last = CW'(supervisor_pkg::RST_PULSE_LONG_TICKS - 1);
    end else begin
      pulse_last = CW'(supervisor_pkg::RST_PULSE_SHORT_TICKS - 1);
    end
    if (long_q) begin
      wd_last = CW'(supervisor_pkg::WD_LONG_TICKS - 1);
    end else if (ext_mode) begin
      wd_last = CW'(EXT_WD_TICKS - 1);
    end else if (ext_level_s) begin
      wd_last = CW'(supervisor_pkg::WD_LONG_TICKS - 1);
    end else begin
      wd_last = CW'(supervisor_pkg::WD_SHORT_TICKS - 1);
    end
  end

  always_comb begin
    state_d = state_q;
    rst_cnt_d = rst_cnt_q;
    wd_cnt_d = wd_cnt_q;
    long_d = long_q;
    fault_n_d = fault_n_q;
    last_kick_d = kick_valid ? kick_high_s : last_kick_q;
    kick_seen_d = kick_valid;
    if (kick_edge) begin
      fault_n_d = 1'b1;
    end
    case (state_q)
      supervisor_pkg::ST_SUPPLY_LOW: begin
        rst_cnt_d = '0;
        if (supply_ok_s) begin
          state_d = supervisor_pkg::ST_STRETCH;
        end
      end
      supervisor_pkg::ST_STRETCH: begin
        if (rst_tick) begin
          if (rst_cnt_q >= pulse_last) begin
            state_d = supervisor_pkg::ST_RUN;
            wd_cnt_d = '0;
            long_d = 1'b1;
          end else begin
            rst_cnt_d = rst_cnt_q + CW'(1);
          end
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (!kick_valid) begin
          wd_cnt_d = '0;
        end else if (kick_edge) begin
          wd_cnt_d = '0;
          long_d = 1'b0;
        end else if (wd_tick) begin
          if (wd_cnt_q >= wd_last) begin
            state_d = supervisor_pkg::ST_STRETCH;
            rst_cnt_d = '0;
            wd_cnt_d = '0;
            fault_n_d = 1'b0;
          end else begin
            wd_cnt_d = wd_cnt_q + CW'(1);
          end
        end
      end
      default: begin
        state_d = supervisor_pkg::ST_SUPPLY_LOW;
      end
    endcase
    if (!kick_valid) begin
      fault_n_d = 1'b1;
    end
    if (!supply_ok_s) begin
      state_d = supervisor_pkg::ST_SUPPLY_LOW;
      rst_cnt_d = '0;
      fault_n_d = 1'b1;
    end
    reset_n_d = (state_d == supervisor_pkg::ST_RUN);
    supply_low_n_d = supply_ok_s;
    pf_n_d = !(pf_below_s || on_backup_s);
    ce_out_n_d = ce_in_n_s || !supply_ok_s;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= supervisor_pkg::ST_SUPPLY_LOW;
      rst_cnt_q <= '0;
      wd_cnt_q <= '0;
      long_q <= 1'b1;
      last_kick_q <= 1'b0;
      kick_seen_q <= 1'b0;
      fault_n_q <= 1'b1;
      reset_n_q <= 1'b0;
      reset_q <= 1'b1;
      supply_low_n_q <= 1'b0;
      pf_n_q <= 1'b0;
      backup_q <= 1'b0;
      ce_out_n_q <= 1'b1;
    end else if (clk_en_i) begin
      state_q <= state_d;
      rst_cnt_q <= rst_cnt_d;
      wd_cnt_q <= wd_cnt_d;
      long_q <= long_d;
      last_kick_q <= last_kick_d;
      kick_seen_q <= kick_seen_d;
      fault_n_q <= fault_n_d;
      reset_n_q <= reset_n_d;
      reset_q <= !reset_n_d;
      supply_low_n_q <= supply_low_n_d;
      pf_n_q <= pf_n_d;
      backup_q <= on_backup_s;
      ce_out_n_q <= ce_out_n_d;
    end
  end

  assign reset_n_o = reset_n_q;
  assign reset_o = reset_q;
  assign watchdog_fault_n_o = fault_n_q;
  assign supply_low_n_o = supply_low_n_q;
  assign power_fail_flag_n_o = pf_n_q;
  assign on_backup_supply_o = backup_q;
  assign ce_out_n_o = ce_out_n_q;

  // ----------------------------------------
  // AXI4-Lite register slave
  // ----------------------------------------
  logic aw_held_q;
  logic aw_held_d;
  logic [7:0] awaddr_q;
  logic [7:0] awaddr_d;
  logic w_held_q;
  logic w_held_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0] wstrb_q;
  logic [3:0] wstrb_d;
  logic awready_q;
  logic awready_d;
  logic wready_q;
  logic wready_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [31:0] status;

  always_comb begin
    status = 32'h00000000;
    status[supervisor_pkg::STAT_RESET_BIT] = !reset_n_q;
    status[supervisor_pkg::STAT_FAULT_BIT] = !fault_n_q;
    status[supervisor_pkg::STAT_SUPPLY_LOW_BIT] = !supply_low_n_q;
    status[supervisor_pkg::STAT_BACKUP_BIT] = backup_q;
    status[supervisor_pkg::STAT_LONG_TIMEOUT_BIT] = long_q;
    status[supervisor_pkg::STAT_WD_ENABLED_BIT] = kick_valid;
    status[supervisor_pkg::STAT_POWER_FAIL_BIT] = !pf_n_q;
    status[supervisor_pkg::STAT_EXT_MODE_BIT] = ext_mode;
  end

  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d = awaddr_q;
    w_held_d = w_held_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    if (bvalid_q && bready_i) begin
      bvalid_d = 1'b0;
    end
    if (aw_held_q && w_held_q && !bvalid_q) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = supervisor_pkg::RESP_OKAY;
      if (awaddr_q[7:2] == supervisor_pkg::CTRL_OFFSET[7:2]) begin
        if (wstrb_q[0]) begin
          ctrl_d[supervisor_pkg::CTRL_LONG_PULSE_BIT] =
            wdata_q[supervisor_pkg::CTRL_LONG_PULSE_BIT];
        end
      end else if (awaddr_q[7:2] != supervisor_pkg::STATUS_OFFSET[7:2]) begin
        bresp_d = supervisor_pkg::RESP_SLVERR;
      end
    end
    if (awvalid_i && awready_q) begin
      aw_held_d = 1'b1;
      awaddr_d = awaddr_i;
    end
    if (wvalid_i && wready_q) begin
      w_held_d = 1'b1;
      wdata_d = wdata_i;
      wstrb_d = wstrb_i;
    end
    if (rvalid_q && rready_i) begin
      rvalid_d = 1'b0;
    end
    if (arvalid_i && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = supervisor_pkg::RESP_OKAY;
      if (araddr_i[7:2] == supervisor_pkg::CTRL_OFFSET[7:2]) begin
        rdata_d = ctrl_q;
      end else if (araddr_i[7:2] == supervisor_pkg::STATUS_OFFSET[7:2]) begin
        rdata_d = status;
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = supervisor_pkg::RESP_SLVERR;
      end
    end
    awready_d = !aw_held_d;
    wready_d = !w_held_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
      ctrl_q <= supervisor_pkg::CTRL_RESET;
    end else if (clk_en_i) begin
      aw_held_q <= aw_held_d;
      awaddr_q <= awaddr_d;
      w_held_q <= w_held_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign awready_o = awready_q;
  assign wready_o = wready_q;
  assign bvalid_o = bvalid_q;
  assign bresp_o = bresp_q;
  assign arready_o = arready_q;
  assign rvalid_o = rvalid_q;
  assign rdata_o = rdata_q;
  assign rresp_o = rresp_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_RESET_ON_LOW_SUPPLY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i && !supply_ok_s |=> !reset_n_o)
    else $error("reset not held while supply low");

  AST_RESET_INVERSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    reset_o == !reset_n_o)
    else $error("active-high reset not inverse of reset");

  AST_SUPPLY_FLAG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i |=> supply_low_n_o == $past(supply_ok_s))
    else $error("supply-low flag lags the threshold");

  AST_CE_BLOCKED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i && (!supply_ok_s || ce_in_n_s) |=> ce_out_n_o)
    else $error("chip enable passed while blocked");

  AST_CE_PASS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i && supply_ok_s && !ce_in_n_s |=> !ce_out_n_o)
    else $error("chip enable not passed");

  AST_PF_BACKUP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i && (on_backup_s || pf_below_s) |=> !power_fail_flag_n_o)
    else $error("power-fail flag high on backup or low sense");

  AST_BACKUP_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i |=> on_backup_supply_o == $past(on_backup_s))
    else $error("backup indicator wrong");

  AST_FAULT_DISABLED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i && (!kick_valid || !supply_ok_s) |=> watchdog_fault_n_o)
    else $error("fault low while disabled or supply low");

  AST_EXPIRY_PULSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(watchdog_fault_n_o) |-> !reset_n_o && state_q == supervisor_pkg::ST_STRETCH)
    else $error("fault without reset pulse");

  AST_LONG_AFTER_RESET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(reset_n_o) |-> long_q && wd_cnt_q == '0)
    else $error("watchdog not restarted long after reset");

endmodule

// ===== cpu_kick_model.sv
// Processor model servicing the watchdog kick line
module cpu_kick_model (
  input wire logic ref_clk_i,
  input wire logic [1:0] mode_i,
  input wire logic level_i,
  input wire logic [15:0] half_period_i,
  output logic kick_high_o,
  output logic kick_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Mode 0 float, 1 static level, 2 toggling
  // ----------------------------------------
  logic lvl_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;
  always_ff @(posedge ref_clk_i) begin
    if (mode_i != 2'h2) begin
      cnt_q <= 16'h0000;
      lvl_q <= level_i;
    end else if (cnt_q >= half_period_i - 16'h0001) begin
      cnt_q <= 16'h0000;
      lvl_q <= ~lvl_q;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // Floating line drives neither comparator
  assign kick_high_o = (mode_i != 2'h0) && lvl_q;
  assign kick_low_o = (mode_i != 2'h0) && !lvl_q;
endmodule

// ===== supervisor_reset_watchdog_tb_top.sv
// Testbench for the supervisor block
module supervisor_reset_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic ref_clk_i, rst_i, supply_ok_i, on_backup_i, power_fail_sense_i;
  logic kick_high_i, kick_low_i, timebase_source_select_i, external_timebase_in_i, ce_in_n_i;
  logic reset_n_o, reset_o, watchdog_fault_n_o, supply_low_n_o, power_fail_flag_n_o;
  logic on_backup_supply_o, ce_out_n_o, awvalid_i, awready_o, wvalid_i, wready_o;
  logic bvalid_o, bready_i, arvalid_i, arready_o, rvalid_o, rready_i, ext_run, lvl, clk_en;
  logic [7:0] awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0] wstrb_i;
  logic [1:0] bresp_o, rresp_o, mode;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  cpu_kick_model cpu_u (.ref_clk_i(ref_clk_i), .mode_i(mode), .level_i(lvl),
    .half_period_i(16'h012C), .kick_high_o(kick_high_i), .kick_low_o(kick_low_i));
  supervisor_reset_watchdog #(.TICK_CYCLES(10), .EXT_RST_TICKS(8), .EXT_WD_TICKS(16)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .supply_ok_i(supply_ok_i),
    .on_backup_i(on_backup_i), .power_fail_sense_i(power_fail_sense_i),
    .kick_high_i(kick_high_i), .kick_low_i(kick_low_i),
    .timebase_source_select_i(timebase_source_select_i),
    .external_timebase_in_i(external_timebase_in_i), .ce_in_n_i(ce_in_n_i),
    .reset_n_o(reset_n_o), .reset_o(reset_o), .watchdog_fault_n_o(watchdog_fault_n_o),
    .supply_low_n_o(supply_low_n_o), .power_fail_flag_n_o(power_fail_flag_n_o),
    .on_backup_supply_o(on_backup_supply_o), .ce_out_n_o(ce_out_n_o),
    .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
    .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
    .rready_i(rready_i));
  // ----------------------------------------
  // Clock, external timebase, timeout
  // ----------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    external_timebase_in_i = 1'b0;
    forever begin
      repeat (20) @(posedge ref_clk_i);
      if (ext_run) external_timebase_in_i <= ~external_timebase_in_i;
    end
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("fails=%0d n_checks=%0d", fails, n_checks);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  function automatic logic pick(input int w);
    return (w == 0) ? reset_n_o : watchdog_fault_n_o;
  endfunction
  task automatic wait_sig(input int w, input logic v, input int max);
    int i;
    i = 0;
    while (pick(w) !== v && i < max) begin
      @(negedge ref_clk_i);
      i++;
    end
    chk(pick(w), v);
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    @(posedge ref_clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (aw && awready_o === 1'b1) begin
        aw = 1'b0;
        awvalid_i <= 1'b0;
      end
      if (w && wready_o === 1'b1) begin
        w = 1'b0;
        wvalid_i <= 1'b0;
      end
    end while (aw || w);
    do @(posedge ref_clk_i); while (bvalid_o !== 1'b1);
    chk32({30'h0, bresp_o}, {30'h0, er});
    bready_i <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do @(posedge ref_clk_i); while (arready_o !== 1'b1);
    arvalid_i <= 1'b0;
    do @(posedge ref_clk_i); while (rvalid_o !== 1'b1);
    chk32(rdata_o, ed);
    chk32({30'h0, rresp_o}, {30'h0, er});
    rready_i <= 1'b0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    supply_ok_i = 1'b0;
    on_backup_i = 1'b1;
    power_fail_sense_i = 1'b0;
    timebase_source_select_i = 1'b1;
    ce_in_n_i = 1'b0;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, ext_run, lvl} = 7'h00;
    clk_en = 1'b1;
    awaddr_i = 8'h00;
    araddr_i = 8'h00;
    wdata_i = 32'h00000000;
    wstrb_i = 4'hF;
    mode = 2'h1;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cyc(10);
    chk(reset_n_o, 1'b0);
    chk(reset_o, 1'b1);
    chk(supply_low_n_o, 1'b0);
    chk(ce_out_n_o, 1'b1);
    chk(power_fail_flag_n_o, 1'b0);
    chk(on_backup_supply_o, 1'b1);
    chk(watchdog_fault_n_o, 1'b1);
    axi_read(8'h10, 32'h00000000, supervisor_pkg::RESP_SLVERR);
    axi_read(supervisor_pkg::STATUS_OFFSET, 32'h0000007D, supervisor_pkg::RESP_OKAY);
    axi_write(supervisor_pkg::CTRL_OFFSET, 32'h00000000, supervisor_pkg::RESP_OKAY);
    @(posedge ref_clk_i);
    on_backup_i <= 1'b0;
    supply_ok_i <= 1'b1;
    cyc(10);
    chk(supply_low_n_o, 1'b1);
    chk(power_fail_flag_n_o, 1'b1);
    chk(on_backup_supply_o, 1'b0);
    chk(ce_out_n_o, 1'b0);
    @(posedge ref_clk_i);
    power_fail_sense_i <= 1'b1;
    ce_in_n_i <= 1'b1;
    cyc(10);
    chk(power_fail_flag_n_o, 1'b0);
    chk(ce_out_n_o, 1'b1);
    cyc(420);
    chk(reset_n_o, 1'b0);
    wait_sig(0, 1'b1, 150);
    chk(reset_o, 1'b0);
    cyc(12000);
    chk(watchdog_fault_n_o, 1'b1);
    wait_sig(1, 1'b0, 5000);
    chk(reset_n_o, 1'b0);
    cyc(440);
    chk(reset_n_o, 1'b0);
    wait_sig(0, 1'b1, 150);
    mode = 2'h2;
    wait_sig(1, 1'b1, 400);
    cyc(5000);
    chk(reset_n_o, 1'b1);
    chk(watchdog_fault_n_o, 1'b1);
    mode = 2'h0;
    cyc(3000);
    chk(watchdog_fault_n_o, 1'b1);
    chk(reset_n_o, 1'b1);
    @(posedge ref_clk_i);
    clk_en <= 1'b0;
    supply_ok_i <= 1'b0;
    cyc(20);
    chk(reset_n_o, 1'b1);
    chk(supply_low_n_o, 1'b1);
    @(posedge ref_clk_i);
    clk_en <= 1'b1;
    supply_ok_i <= 1'b1;
    cyc(10);
    chk(reset_n_o, 1'b1);
    lvl = 1'b0;
    mode = 2'h1;
    cyc(500);
    lvl = 1'b1;
    cyc(900);
    chk(watchdog_fault_n_o, 1'b1);
    wait_sig(1, 1'b0, 300);
    chk(reset_n_o, 1'b0);
    @(posedge ref_clk_i);
    supply_ok_i <= 1'b0;
    cyc(10);
    chk(watchdog_fault_n_o, 1'b1);
    chk(supply_low_n_o, 1'b0);
    axi_write(supervisor_pkg::CTRL_OFFSET, 32'h00000001, supervisor_pkg::RESP_OKAY);
    axi_read(supervisor_pkg::CTRL_OFFSET, 32'h00000001, supervisor_pkg::RESP_OKAY);
    @(posedge ref_clk_i);
    supply_ok_i <= 1'b1;
    cyc(1900);
    chk(reset_n_o, 1'b0);
    wait_sig(0, 1'b1, 200);
    axi_write(supervisor_pkg::CTRL_OFFSET, 32'h00000000, supervisor_pkg::RESP_OKAY);
    @(posedge ref_clk_i);
    supply_ok_i <= 1'b0;
    timebase_source_select_i <= 1'b0;
    ext_run <= 1'b1;
    cyc(20);
    @(posedge ref_clk_i);
    supply_ok_i <= 1'b1;
    cyc(250);
    chk(reset_n_o, 1'b0);
    wait_sig(0, 1'b1, 200);
    finish_test();
  end
endmodule
